/* pmsd_pkg.sv */
// Notes on behaviour
// - Twin 8-bit period is channel B low plus one.
// - Twin 8-bit resolution never exceeds eight bits.
// - Twin 8-bit output A falls at A low.
// - Output B rises at B high, falls A high.
// - Twin 16-bit counter spans full 16 bits.
// - Twin 16-bit output high while counter below word.
// - Both outputs rise together at rollover.
// - Sigma-delta outputs update every counter clock.
// - Sigma-delta high count equals word per 65536.
// - Sigma-delta spreads high slots evenly.
// - Dual 8-bit periods from channel B bytes.
// - Dual 8-bit duties from channel A bytes.
// - Dual 8-bit channels share one clock divider.
// - RZ mode is NRZ with returning pulses.
// - RZ high slot is high first half only, whole slot at divide-by-1.
// - Three-bit field selects the mode.
// - Control write resets the shared counter.
// - In 16-bit modes low byte held until high byte write.
// - Divider field scales by 1, 4, 16, 64.
package pmsd_pkg;
  localparam int unsigned CLOCK_HZ      = 10_000_000;
  localparam logic [4:0]  OFS_CONTROL   = 5'h00;
  localparam logic [4:0]  OFS_A_LOW     = 5'h04;
  localparam logic [4:0]  OFS_A_HIGH    = 5'h08;
  localparam logic [4:0]  OFS_B_LOW     = 5'h0c;
  localparam logic [4:0]  OFS_B_HIGH    = 5'h10;
  localparam logic [4:0]  OFS_STATUS    = 5'h14;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  CONTROL_MASK  = 8'h7f;
  localparam int          MODE_LSB      = 4;
  localparam int          MODE_MSB      = 6;
  localparam int          DIV_LSB       = 2;
  localparam int          DIV_MSB       = 3;
  localparam logic [7:0]  BYTE_ZERO     = 8'h00;
  localparam logic [15:0] WORD_ZERO     = 16'h0000;
  localparam logic [15:0] CNT_MAX       = 16'hffff;
  localparam logic [15:0] CNT_STEP      = 16'h0001;
  localparam logic [7:0]  BYTE_STEP     = 8'h01;
  localparam logic [5:0]  DIV1_LIMIT    = 6'h00;
  localparam logic [5:0]  DIV4_LIMIT    = 6'h03;
  localparam logic [5:0]  DIV16_LIMIT   = 6'h0f;
  localparam logic [5:0]  DIV64_LIMIT   = 6'h3f;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_OFF    = 3'h0,
    MODE_SINGLE = 3'h1,
    MODE_TWIN8  = 3'h2,
    MODE_TWIN16 = 3'h3,
    MODE_NRZ    = 3'h4,
    MODE_DUAL8  = 3'h5,
    MODE_RZ     = 3'h6,
    MODE_RSVD   = 3'h7
  } pmsd_mode_t;

  function automatic logic mode_is16(input pmsd_mode_t m);
    return (m == MODE_TWIN16) || (m == MODE_NRZ) || (m == MODE_RZ);
  endfunction

  function automatic logic mode_runs(input pmsd_mode_t m);
    return (m == MODE_TWIN8) || (m == MODE_DUAL8) || mode_is16(m);
  endfunction

  function automatic logic [5:0] div_limit(input logic [1:0] sel);
    case (sel)
      2'h0: return DIV1_LIMIT;
      2'h1: return DIV4_LIMIT;
      2'h2: return DIV16_LIMIT;
      default: return DIV64_LIMIT;
    endcase
  endfunction
endpackage

/* pmsd_prescaler.sv */
`timescale 1ns/1ps
module pmsd_prescaler (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clear,
  input  wire logic       run,
  input  wire logic [1:0] div_sel,
  output logic            tick,
  output logic            first_half
);
  import pmsd_pkg::*;

  logic [5:0] count;
  wire  [5:0] limit;
  wire        at_limit;

  assign limit      = div_limit(div_sel);
  assign at_limit   = (count >= limit);
  assign tick       = run && at_limit;
  assign first_half = (count <= (limit >> 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= 6'h00;
    end else if (clear || !run || at_limit) begin
      count <= 6'h00;
    end else begin
      count <= count + 6'h01;
    end
  end

  property p_div_restart;
    @(posedge clock) disable iff (!nrst)
      (tick && !clear && div_sel != 2'h0) |=> (count == 6'h00);
  endproperty
  a_div_restart: assert property (p_div_restart) else $error("Prescaler did not restart.");

  property p_div_spacing;
    @(posedge clock) disable iff (!nrst)
      (tick && !clear && div_sel == 2'h1) ##1 ($stable(div_sel) && !clear) |-> !tick ##1 !tick;
  endproperty
  a_div_spacing: assert property (p_div_spacing) else $error("Divide by four ticked early.");
endmodule

/* pmsd_sigma_delta.sv */
`timescale 1ns/1ps
module pmsd_sigma_delta (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        clear,
  input  wire logic        tick,
  input  wire logic [15:0] level,
  output logic             bit_out
);
  import pmsd_pkg::*;

  logic [15:0] acc;
  wire  [16:0] sum;

  assign sum = {1'b0, acc} + {1'b0, level};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc     <= WORD_ZERO;
      bit_out <= 1'b0;
    end else if (clear) begin
      acc     <= WORD_ZERO;
      bit_out <= 1'b0;
    end else if (tick) begin
      acc     <= sum[15:0];
      bit_out <= sum[16];
    end
  end

  property p_sd_zero;
    @(posedge clock) disable iff (!nrst)
      (tick && !clear && level == WORD_ZERO) |=> !bit_out;
  endproperty
  a_sd_zero: assert property (p_sd_zero) else $error("Zero level produced a high slot.");

  property p_sd_hold;
    @(posedge clock) disable iff (!nrst)
      (!tick && !clear) |=> ($stable(bit_out) && $stable(acc));
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("Modulator moved between ticks.");

  property p_sd_quarter;
    @(posedge clock) disable iff (!nrst)
      (tick && !clear && level == 16'h4010 && acc == WORD_ZERO) |=> !bit_out;
  endproperty
  a_sd_quarter: assert property (p_sd_quarter) else $error("Quarter level high too soon.");
endmodule

/* pmsd_top.sv */
`timescale 1ns/1ps
module pmsd_top (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic             output_a,
  output logic             output_a_en,
  output logic             output_b,
  output logic             output_b_en
);
  import pmsd_pkg::*;

  logic [7:0]  modulator_control;
  logic [7:0]  chan_a_low_byte;
  logic [7:0]  chan_a_high_byte;
  logic [7:0]  chan_b_low_byte;
  logic [7:0]  chan_b_high_byte;
  logic [7:0]  hold_a;
  logic [7:0]  hold_b;
  logic [15:0] active_a;
  logic [15:0] active_b;
  logic [15:0] cnt;
  logic [7:0]  cnt_b;

  wire         accept;
  wire         wr_acc;
  wire         ctrl_wr;
  wire [7:0]   wbyte;
  pmsd_mode_t  mode;
  pmsd_mode_t  new_mode;
  wire [1:0]   clock_divider_field;
  wire         is16;
  wire         running;
  wire         next_running;
  wire         start_a;
  wire         start_b;
  wire         tick;
  wire         first_half;
  wire         sd_a;
  wire         sd_b;
  wire         wrap16;
  wire         wrap_a8;
  wire         wrap_b8;
  wire [15:0]  next_cnt;
  wire [7:0]   next_cnt_b;
  wire [15:0]  next_active_a;
  wire [15:0]  next_active_b;
  wire [15:0]  chan_a_word;
  wire [15:0]  chan_b_word;
  wire [31:0]  next_readdata;
  logic        next_output_a;
  logic        next_output_b;

  // Bus decode.
  assign accept      = (read || write) && !waitrequest;
  assign wr_acc      = write && accept && byteenable[0];
  assign wbyte       = writedata[7:0];
  assign ctrl_wr     = wr_acc && (address == OFS_CONTROL);
  assign mode        = pmsd_mode_t'(modulator_control[MODE_MSB:MODE_LSB]);
  assign clock_divider_field = modulator_control[DIV_MSB:DIV_LSB];
  assign is16        = mode_is16(mode);
  assign running     = mode_runs(mode);
  assign chan_a_word = {chan_a_high_byte, chan_a_low_byte};
  assign chan_b_word = {chan_b_high_byte, chan_b_low_byte};

  assign new_mode     = pmsd_mode_t'(wbyte[MODE_MSB:MODE_LSB]);
  assign next_running = ctrl_wr ? mode_runs(new_mode) : running;
  assign start_a      =
    (new_mode == MODE_TWIN16) ? (chan_a_word != WORD_ZERO) :
    (new_mode == MODE_TWIN8 || new_mode == MODE_DUAL8) ? (chan_a_low_byte != BYTE_ZERO) :
    1'b0;
  assign start_b      =
    (new_mode == MODE_TWIN16) ? (chan_b_word != WORD_ZERO) :
    (new_mode == MODE_DUAL8)  ? (chan_a_high_byte != BYTE_ZERO) :
    (new_mode == MODE_TWIN8)  ? (chan_a_high_byte != BYTE_ZERO) &&
                                (chan_b_high_byte == BYTE_ZERO) : 1'b0;

  assign next_readdata =
    (address == OFS_CONTROL) ? {24'h000000, modulator_control} :
    (address == OFS_A_LOW)   ? {24'h000000, chan_a_low_byte} :
    (address == OFS_A_HIGH)  ? {24'h000000, chan_a_high_byte} :
    (address == OFS_B_LOW)   ? {24'h000000, chan_b_low_byte} :
    (address == OFS_B_HIGH)  ? {24'h000000, chan_b_high_byte} :
    (address == OFS_STATUS)  ? {15'h0000, running, cnt} : UNMAPPED_DATA;

  pmsd_prescaler u_prescaler (
    .clock      (clock),
    .nrst       (nrst),
    .clear      (ctrl_wr),
    .run        (running),
    .div_sel    (clock_divider_field),
    .tick       (tick),
    .first_half (first_half)
  );

  pmsd_sigma_delta u_sd_a (
    .clock   (clock),
    .nrst    (nrst),
    .clear   (ctrl_wr),
    .tick    (tick),
    .level   (active_a),
    .bit_out (sd_a)
  );

  pmsd_sigma_delta u_sd_b (
    .clock   (clock),
    .nrst    (nrst),
    .clear   (ctrl_wr),
    .tick    (tick),
    .level   (active_b),
    .bit_out (sd_b)
  );

  assign wrap_a8 = (cnt[7:0] >= chan_b_low_byte);
  assign wrap_b8 = (cnt_b >= chan_b_high_byte);
  assign wrap16  = tick && is16 && (cnt == CNT_MAX);

  // Byte modes count in eight bits.
  assign next_cnt =
    !tick                                              ? cnt :
    ((mode == MODE_TWIN8 || mode == MODE_DUAL8) && wrap_a8) ? WORD_ZERO :
    (mode == MODE_TWIN8 || mode == MODE_DUAL8)          ? {8'h00, cnt[7:0] + BYTE_STEP} :
    cnt + CNT_STEP;
  assign next_cnt_b = !tick ? cnt_b : (wrap_b8 ? BYTE_ZERO : cnt_b + BYTE_STEP);

  assign next_active_a = (wrap16 || ctrl_wr) ? chan_a_word : active_a;
  assign next_active_b = (wrap16 || ctrl_wr) ? chan_b_word : active_b;

  always_comb begin
    next_output_a = output_a;
    next_output_b = output_b;
    case (mode)
      MODE_TWIN8: begin
        if (tick) begin
          if (next_cnt[7:0] == chan_a_low_byte) begin
            next_output_a = 1'b0;
          end else if (next_cnt[7:0] == BYTE_ZERO) begin
            next_output_a = 1'b1;
          end
          if (next_cnt[7:0] == chan_a_high_byte) begin
            next_output_b = 1'b0;
          end else if (next_cnt[7:0] == chan_b_high_byte) begin
            next_output_b = 1'b1;
          end
        end
      end
      MODE_TWIN16: begin
        next_output_a = (next_cnt < next_active_a);
        next_output_b = (next_cnt < next_active_b);
      end
      MODE_DUAL8: begin
        next_output_a = (next_cnt[7:0] < chan_a_low_byte);
        next_output_b = (next_cnt_b < chan_a_high_byte);
      end
      MODE_NRZ: begin
        next_output_a = sd_a;
        next_output_b = sd_b;
      end
      MODE_RZ: begin
        next_output_a = sd_a && first_half;
        next_output_b = sd_b && first_half;
      end
      default: begin
        next_output_a = 1'b0;
        next_output_b = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata    <= UNMAPPED_DATA;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
      readdata    <= read ? next_readdata : UNMAPPED_DATA;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      modulator_control <= CONTROL_RESET;
      chan_a_low_byte   <= BYTE_ZERO;
      chan_a_high_byte  <= BYTE_ZERO;
      chan_b_low_byte   <= BYTE_ZERO;
      chan_b_high_byte  <= BYTE_ZERO;
      hold_a            <= BYTE_ZERO;
      hold_b            <= BYTE_ZERO;
    end else if (wr_acc) begin
      case (address)
        OFS_CONTROL: modulator_control <= wbyte & CONTROL_MASK;
        OFS_A_LOW: begin
          if (is16) begin
            hold_a <= wbyte;
          end else begin
            chan_a_low_byte <= wbyte;
          end
        end
        OFS_A_HIGH: begin
          chan_a_high_byte <= wbyte;
          if (is16) begin
            chan_a_low_byte <= hold_a;
          end
        end
        OFS_B_LOW: begin
          if (is16) begin
            hold_b <= wbyte;
          end else begin
            chan_b_low_byte <= wbyte;
          end
        end
        OFS_B_HIGH: begin
          chan_b_high_byte <= wbyte;
          if (is16) begin
            chan_b_low_byte <= hold_b;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt         <= WORD_ZERO;
      cnt_b       <= BYTE_ZERO;
      active_a    <= WORD_ZERO;
      active_b    <= WORD_ZERO;
      output_a    <= 1'b0;
      output_b    <= 1'b0;
      output_a_en <= 1'b0;
      output_b_en <= 1'b0;
    end else begin
      output_a_en <= next_running;
      output_b_en <= next_running;
      active_a    <= next_active_a;
      active_b    <= next_active_b;
      if (ctrl_wr) begin
        cnt      <= WORD_ZERO;
        cnt_b    <= BYTE_ZERO;
        output_a <= start_a;
        output_b <= start_b;
      end else if (!running) begin
        cnt      <= WORD_ZERO;
        cnt_b    <= BYTE_ZERO;
        output_a <= 1'b0;
        output_b <= 1'b0;
      end else begin
        cnt      <= next_cnt;
        cnt_b    <= next_cnt_b;
        output_a <= next_output_a;
        output_b <= next_output_b;
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  property p_ctrl_clear;
    ctrl_wr |=> (cnt == WORD_ZERO) && (cnt_b == BYTE_ZERO);
  endproperty
  a_ctrl_clear: assert property (p_ctrl_clear) else $error("Control write kept counter.");

  property p_release;
    (!running && !ctrl_wr) |=> !output_a_en && !output_b_en && !output_a && !output_b
      && (cnt == WORD_ZERO);
  endproperty
  a_release: assert property (p_release) else $error("Stopped mode still drives pins.");

  property p_twin8_period;
    (mode == MODE_TWIN8 && tick && !ctrl_wr && cnt[7:0] >= chan_b_low_byte) |=> (cnt == WORD_ZERO);
  endproperty
  a_twin8_period: assert property (p_twin8_period) else $error("Twin 8-bit missed wrap.");

  property p_twin8_low;
    (mode == MODE_TWIN8 && tick && !ctrl_wr && next_cnt[7:0] == chan_a_low_byte) |=> !output_a;
  endproperty
  a_twin8_low: assert property (p_twin8_low) else $error("Output A did not fall.");

  property p_twin8_b_high;
    (mode == MODE_TWIN8 && tick && !ctrl_wr && next_cnt[7:0] == chan_b_high_byte
     && next_cnt[7:0] != chan_a_high_byte) |=> output_b;
  endproperty
  a_twin8_b_high: assert property (p_twin8_b_high) else $error("Output B did not rise.");

  property p_twin16_sync;
    (mode == MODE_TWIN16 && wrap16 && !ctrl_wr) |=>
      (cnt == WORD_ZERO) && (output_a == (active_a != WORD_ZERO))
      && (output_b == (active_b != WORD_ZERO));
  endproperty
  a_twin16_sync: assert property (p_twin16_sync) else $error("Rollover lost alignment.");

  property p_twin16_level;
    (mode == MODE_TWIN16 && tick && !ctrl_wr) |=> (output_a == (cnt < active_a));
  endproperty
  a_twin16_level: assert property (p_twin16_level) else $error("Output A wrong level.");

  property p_dual8_duty;
    (mode == MODE_DUAL8 && tick && !ctrl_wr) |=> (output_b == (cnt_b < chan_a_high_byte));
  endproperty
  a_dual8_duty: assert property (p_dual8_duty) else $error("Output B duty wrong.");

  property p_rz_return;
    (mode == MODE_RZ && !ctrl_wr && !first_half) |=> !output_a && !output_b;
  endproperty
  a_rz_return: assert property (p_rz_return) else $error("Return-to-zero slot held high.");

  c_twin8_wrap: cover property (mode == MODE_TWIN8 && tick && wrap_a8 ##1 output_a);
  c_twin16_roll: cover property (mode == MODE_TWIN16 && wrap16);
  c_nrz_high: cover property (mode == MODE_NRZ && output_a ##1 !output_a);
  c_rz_pulse: cover property (mode == MODE_RZ && output_b);
endmodule

/* pmsd_load.sv */
`timescale 1ns/1ps
// Resistive load with pull-downs on both pins; it tallies high cycles.
module pmsd_load (
  input  wire logic  clock,
  input  wire logic  clr,
  input  wire logic  output_a,
  input  wire logic  output_a_en,
  input  wire logic  output_b,
  input  wire logic  output_b_en,
  output logic [31:0] hi_a,
  output logic [31:0] hi_b,
  output logic [31:0] run_a,
  output logic [31:0] run_b
);
  logic        pin_a;
  logic        pin_b;
  logic [31:0] cur_a;
  logic [31:0] cur_b;
  // A released pin is held low by its pull-down.
  assign pin_a = output_a_en ? output_a : 1'b0;
  assign pin_b = output_b_en ? output_b : 1'b0;
  always_ff @(posedge clock) begin
    if (clr) begin
      hi_a  <= 32'h0;
      hi_b  <= 32'h0;
      cur_a <= 32'h0;
      cur_b <= 32'h0;
      run_a <= 32'h0;
      run_b <= 32'h0;
    end else begin
      hi_a  <= hi_a + {31'h0, pin_a};
      hi_b  <= hi_b + {31'h0, pin_b};
      cur_a <= pin_a ? cur_a + 32'h1 : 32'h0;
      cur_b <= pin_b ? cur_b + 32'h1 : 32'h0;
      if (pin_a && cur_a + 32'h1 > run_a) run_a <= cur_a + 32'h1;
      if (pin_b && cur_b + 32'h1 > run_b) run_b <= cur_b + 32'h1;
    end
  end
endmodule

/* tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pmsd_pkg::*;
  logic        clock;
  logic        nrst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        output_a;
  logic        output_a_en;
  logic        output_b;
  logic        output_b_en;
  logic        clr;
  logic [31:0] hi_a;
  logic [31:0] hi_b;
  logic [31:0] run_a;
  logic [31:0] run_b;
  logic [31:0] q;
  int          bad_count;
  int          samples_checked;
  int          cycles;
  pmsd_mode_t  stop_modes [3] = '{MODE_RSVD, MODE_SINGLE, MODE_OFF};

  pmsd_top DUT (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .output_a(output_a), .output_a_en(output_a_en),
    .output_b(output_b), .output_b_en(output_b_en));
  pmsd_load load (.clock(clock), .clr(clr), .output_a(output_a), .output_a_en(output_a_en),
    .output_b(output_b), .output_b_en(output_b_en), .hi_a(hi_a), .hi_b(hi_b),
    .run_a(run_a), .run_b(run_b));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      bad_count++;
    end
  endtask

  task automatic bus(input logic rd, input logic [4:0] adr, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clock);
    read       <= rd;
    write      <= !rd;
    address    <= adr;
    writedata  <= {24'h0, d};
    byteenable <= be;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] adr, input logic [7:0] d);
    bus(1'b0, adr, d, 4'hf);
  endtask

  task automatic rd_chk(input string what, input logic [4:0] adr, input logic [31:0] exp);
    bus(1'b1, adr, 8'h00, 4'hf);
    chk(what, exp, q);
  endtask

  function automatic logic [7:0] ctl(input pmsd_mode_t m, input logic [1:0] dv);
    return {1'b0, m, dv, 2'h0};
  endfunction

  // Programs all four data bytes, then rewrites control so the words load.
  task automatic setup(input pmsd_mode_t m, input logic [1:0] dv, input logic [7:0] al,
                       input logic [7:0] ah, input logic [7:0] bl, input logic [7:0] bh);
    wr(OFS_CONTROL, ctl(m, dv));
    wr(OFS_A_LOW, al);
    wr(OFS_A_HIGH, ah);
    wr(OFS_B_LOW, bl);
    wr(OFS_B_HIGH, bh);
    wr(OFS_CONTROL, ctl(m, dv));
  endtask

  task automatic clear_load();
    @(posedge clock);
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask

  task automatic measure(input int n);
    repeat (20) @(posedge clock);
    clear_load();
    repeat (n) @(posedge clock);
    #1;
  endtask

  initial begin
    nrst = 1'b0;
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    clr = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rd_chk("control reset", OFS_CONTROL, 32'h0);
    rd_chk("unmapped read", 5'h18, 32'h0);
    $display("test registers done");

    wr(OFS_CONTROL, ctl(MODE_TWIN16, 2'h0));
    wr(OFS_A_LOW, 8'h10);
    rd_chk("low held", OFS_A_LOW, 32'h0);
    wr(OFS_A_HIGH, 8'h00);
    rd_chk("low moved", OFS_A_LOW, 32'h10);
    bus(1'b0, OFS_A_LOW, 8'h55, 4'he);
    rd_chk("byteenable ignored", OFS_A_LOW, 32'h10);
    wr(OFS_B_LOW, 8'h20);
    wr(OFS_B_HIGH, 8'h00);
    wr(OFS_CONTROL, ctl(MODE_OFF, 2'h0));
    clear_load();
    wr(OFS_CONTROL, ctl(MODE_TWIN16, 2'h0));
    repeat (300) @(posedge clock);
    #1;
    chk("twin16 a high", 32'd16, hi_a);
    chk("twin16 b high", 32'd32, hi_b);
    $display("test twin16 done");

    // Period 10 counts, B high byte zero aligns both starts.
    setup(MODE_TWIN8, 2'h0, 8'h03, 8'h07, 8'h09, 8'h00);
    measure(100);
    chk("twin8 a high", 32'd30, hi_a);
    chk("twin8 b high", 32'd70, hi_b);
    $display("test twin8 done");

    setup(MODE_DUAL8, 2'h2, 8'h03, 8'h02, 8'h09, 8'h04);
    rd_chk("status after control", OFS_STATUS, 32'h10000);
    measure(1600);
    chk("dual8 a high", 32'd480, hi_a);
    chk("dual8 b high", 32'd640, hi_b);
    $display("test dual8 done");

    // Fastest divider; B keeps only its lowest bit of each byte.
    setup(MODE_NRZ, 2'h0, 8'h10, 8'h40, 8'h01, 8'h01);
    measure(65536);
    chk("nrz a high", 32'd16400, hi_a);
    chk("nrz b high", 32'd257, hi_b);
    chk("nrz a run", 32'd1, run_a);
    $display("test nrz done");

    setup(MODE_RZ, 2'h1, 8'h00, 8'h80, 8'h00, 8'h40);
    measure(1600);
    chk("rz a high", 32'd400, hi_a);
    chk("rz b high", 32'd200, hi_b);
    chk("rz a run", 32'd2, run_a);
    $display("test rz done");

    foreach (stop_modes[k]) begin
      wr(OFS_CONTROL, ctl(stop_modes[k], 2'h0));
      repeat (4) @(posedge clock);
      chk("stopped enable a", 32'h0, {31'h0, output_a_en});
      chk("stopped enable b", 32'h0, {31'h0, output_b_en});
      rd_chk("stopped status", OFS_STATUS, 32'h0);
    end
    $display("test off modes done");
    end_sim();
  end
endmodule
